// ### rtl/sfs_params.svh
/*
  Constants of the serial flash front end: array geometry, address
  layout, frame layout and idle values.
  Assumes it is included by bare name from rtl/ sources.
*/
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH
`define SFS_ADDR_W       24
`define SFS_ARRAY_BYTES  4194304
`define SFS_BLOCKS       64
`define SFS_SECTORS      1024
`define SFS_PAGES        16384
`define SFS_PAGE_BYTES   9'h100
`define SFS_SECTOR_MASK  24'hFFF000
`define SFS_BLOCK_MASK   24'hFF0000
`define SFS_CHIP_BASE    24'h000000
`define SFS_ADDR_FIRST   10'h001
`define SFS_ADDR_LAST    10'h003
`define SFS_DATA_FIRST   10'h004
`define SFS_BYTE_MAX     10'h3FF
`define SFS_IDLE_BYTE    8'hFF
`define SFS_BIT_LAST     3'h7
`define SFS_BP_ALL       4'h7
`endif

// ### rtl/sfs_pkg.sv
/*
  Types of the serial flash front end: lane modes, frame states,
  erase sizes and the address and receive carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sfs_pkg;
  // Lines in use per transfer
  typedef enum logic [1:0] {SFS_LANE_SINGLE, SFS_LANE_DUAL, SFS_LANE_QUAD} sfs_lane_e;
  // Frame states
  typedef enum logic [1:0] {SFS_ST_WAIT_HIGH, SFS_ST_IDLE, SFS_ST_ACTIVE} sfs_state_e;
  // Erase sizes; there is no page erase
  typedef enum logic [1:0] {SFS_ER_SECTOR, SFS_ER_BLOCK, SFS_ER_CHIP} sfs_erase_e;
  // Linear byte address split into array units
  typedef struct packed {
    logic [5:0] block;
    logic [3:0] sector;
    logic [3:0] page;
    logic [7:0] offset;
  } sfs_addr_s;
  // Received byte with its place in the frame
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } sfs_rx_s;
endpackage

// ### rtl/sfs_sync.sv
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes inputs are asynchronous to clk_sys_i.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second; both reset low, so a select pin held
  // low through reset never looks like a high, and a low clock shows no edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ### rtl/sfs_buf2.sv
/*
  Two-entry buffer with valid and ready on both sides; the head entry
  and both flags come straight from flip-flops.
  Assumes source and sink share clk_sys_i.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_buf2 #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  // Filling side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output var  logic         in_ready_o,
  // Draining side
  output var  logic         out_valid_o,
  output var  logic [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  logic         v1, next_v0, next_v1;
  logic [W-1:0] d1, next_d0, next_d1;
  logic         push, pop;

  // Next entries: head shifts forward on pop
  always_comb begin
    push    = in_valid_i && !v1;
    pop     = out_valid_o && out_ready_i;
    next_v0 = out_valid_o;
    next_v1 = v1;
    next_d0 = out_data_o;
    next_d1 = d1;
    if (pop) begin
      if (v1) begin
        next_d0 = d1;
        next_v1 = push;
        if (push) next_d1 = in_data_i;
      end else begin
        next_v0 = push;
        if (push) next_d0 = in_data_i;
      end
    end else if (push) begin
      if (!out_valid_o) begin
        next_v0 = 1'b1;
        next_d0 = in_data_i;
      end else begin
        next_v1 = 1'b1;
        next_d1 = in_data_i;
      end
    end
  end

  // Entry registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      v1          <= 1'b0;
      out_data_o  <= '0;
      d1          <= '0;
    end else begin
      out_valid_o <= next_v0;
      v1          <= next_v1;
      out_data_o  <= next_d0;
      d1          <= next_d1;
    end
  end

  assign in_ready_o = !v1;
endmodule
`default_nettype wire

// ### rtl/sfs_front_end.sv
/*
  Serial flash front end, device side: samples the serial clock,
  chip select and four I/O lines, shifts bytes in and out in single,
  dual or quad lanes, handles pause and write protect and splits the
  frame address into array units.
  Assumes the flash core picks the lane mode and direction per frame
  and serves bytes on tx_data_i; pins are asynchronous to clk_sys_i,
  whose rate is well above the serial clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sfs_params.svh"
module sfs_front_end (
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               reset_n_i,
  // Serial pins
  input  wire logic               spi_clk_i,
  input  wire logic               chip_sel_n_i,
  input  wire logic               io_line_0_i,
  input  wire logic               io_line_1_i,
  input  wire logic               io_line_2_i,
  input  wire logic               io_line_3_i,
  output var  logic               io_line_0_o,
  output var  logic               io_line_1_o,
  output var  logic               io_line_2_o,
  output var  logic               io_line_3_o,
  output var  logic               io_line_0_oe_n_o,
  output var  logic               io_line_1_oe_n_o,
  output var  logic               io_line_2_oe_n_o,
  output var  logic               io_line_3_oe_n_o,
  // Core control
  input  wire sfs_pkg::sfs_lane_e lane_mode_i,
  input  wire logic               drive_out_i,
  input  wire logic               internal_busy_i,
  input  wire logic               status_lock_bit_i,
  input  wire logic [3:0]         protect_range_bits_i,
  input  wire sfs_pkg::sfs_erase_e erase_kind_i,
  input  wire logic [7:0]         old_byte_i,
  // Received bytes
  output var  logic               rx_valid_o,
  output var  sfs_pkg::sfs_rx_s   rx_o,
  input  wire logic               rx_ready_i,
  output var  logic               rx_overrun_o,
  // Bytes to send
  input  wire logic               tx_valid_i,
  input  wire logic [7:0]         tx_data_i,
  output var  logic               tx_ack_o,
  // Status to the core
  output var  logic               selected_o,
  output var  logic               cycle_busy_o,
  output var  sfs_pkg::sfs_addr_s addr_o,
  output var  logic               addr_valid_o,
  output var  logic               addr_protected_o,
  output var  logic               status_write_block_o,
  output var  logic [8:0]         prog_count_o,
  output var  logic               prog_over_o,
  output var  logic [7:0]         prog_byte_o,
  output var  logic [23:0]        erase_base_o
);
  import sfs_pkg::*;

  logic [5:0] pins_s;
  logic       sclk_s, cs_n_s, sclk_prev;
  logic [3:0] io_s;
  logic       rise, fall, hold_act, quad;
  sfs_state_e state, next_state;

  // Pins pass two flip-flops before use
  sfs_sync #(.W(6)) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   ({spi_clk_i, chip_sel_n_i, io_line_3_i, io_line_2_i,
                 io_line_1_i, io_line_0_i}),
    .sync_o    (pins_s)
  );

  // Edges and pin roles
  assign sclk_s   = pins_s[5];
  assign cs_n_s   = pins_s[4];
  assign io_s     = pins_s[3:0];
  assign quad     = (lane_mode_i == SFS_LANE_QUAD);
  assign hold_act = !cs_n_s && !io_s[3] && !quad;
  // Idle level of the clock is not looked at, so mode 0 and 3 both work
  assign rise     = sclk_s && !sclk_prev && !hold_act;
  assign fall     = !sclk_s && sclk_prev && !hold_act;

  // Frame state: wait for a high select after power-up
  always_comb begin
    next_state = state;
    unique case (state)
      SFS_ST_WAIT_HIGH: if (cs_n_s) next_state = SFS_ST_IDLE;
      SFS_ST_IDLE:      if (!cs_n_s) next_state = SFS_ST_ACTIVE;
      SFS_ST_ACTIVE:    if (cs_n_s) next_state = SFS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state     <= SFS_ST_WAIT_HIGH;
      sclk_prev <= 1'b0;
    end else begin
      state     <= next_state;
      sclk_prev <= sclk_s;
    end
  end

  logic       active;
  logic [2:0] bit_cnt, next_bit_cnt, tx_cnt, next_tx_cnt, step;
  logic [7:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh, rx_byte;
  logic [9:0] byte_cnt, next_byte_cnt;
  logic       rx_push, buf_ready, next_overrun, next_ack;

  assign active = (state == SFS_ST_ACTIVE) && !cs_n_s;
  assign step   = (lane_mode_i == SFS_LANE_QUAD) ? 3'h4 :
                  (lane_mode_i == SFS_LANE_DUAL) ? 3'h2 : 3'h1;

  // Shift in on rising edges, out on falling edges
  always_comb begin
    next_rx_sh    = rx_sh;
    next_bit_cnt  = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_tx_sh    = tx_sh;
    next_tx_cnt   = tx_cnt;
    next_ack      = 1'b0;
    next_overrun  = rx_overrun_o;
    rx_push       = 1'b0;
    rx_byte       = rx_sh;
    if (!active) begin
      next_bit_cnt  = '0;
      next_byte_cnt = '0;
      next_tx_cnt   = '0;
      next_overrun  = 1'b0;
    end else begin
      if (rise && !drive_out_i) begin
        unique case (lane_mode_i)
          SFS_LANE_SINGLE: next_rx_sh = {rx_sh[6:0], io_s[0]};
          SFS_LANE_DUAL:   next_rx_sh = {rx_sh[5:0], io_s[1:0]};
          default:         next_rx_sh = {rx_sh[3:0], io_s};
        endcase
        next_bit_cnt = bit_cnt + step;
        if (bit_cnt + step == 3'h0) begin
          rx_push = 1'b1;
          rx_byte = next_rx_sh;
          if (!buf_ready) next_overrun = 1'b1;
          if (byte_cnt != `SFS_BYTE_MAX) next_byte_cnt = byte_cnt + 10'h001;
        end
      end
      if (fall && drive_out_i) begin
        if (tx_cnt == 3'h0) begin
          next_tx_sh = tx_valid_i ? tx_data_i : `SFS_IDLE_BYTE;
          next_ack   = tx_valid_i;
        end else begin
          next_tx_sh = tx_sh << step;
        end
        next_tx_cnt = tx_cnt + step;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sh        <= '0;
      bit_cnt      <= '0;
      byte_cnt     <= '0;
      tx_sh        <= `SFS_IDLE_BYTE;
      tx_cnt       <= '0;
      tx_ack_o     <= 1'b0;
      rx_overrun_o <= 1'b0;
    end else begin
      rx_sh        <= next_rx_sh;
      bit_cnt      <= next_bit_cnt;
      byte_cnt     <= next_byte_cnt;
      tx_sh        <= next_tx_sh;
      tx_cnt       <= next_tx_cnt;
      tx_ack_o     <= next_ack;
      rx_overrun_o <= next_overrun;
    end
  end

  // Received bytes wait here until the core takes them
  sfs_buf2 #(.W(9)) u_rx_buf (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (rx_push),
    .in_data_i   ({byte_cnt == 10'h000, rx_byte}),
    .in_ready_o  (buf_ready),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_o),
    .out_ready_i (rx_ready_i)
  );

  logic [3:0] next_io, next_oe_n;

  // Output lines: launched from the shift register after a falling edge
  always_comb begin
    next_io   = {io_line_3_o, io_line_2_o, io_line_1_o, io_line_0_o};
    next_oe_n = 4'hF;
    if (active && !hold_act && drive_out_i) begin
      unique case (lane_mode_i)
        SFS_LANE_SINGLE: begin
          next_oe_n = 4'hD;
          next_io[1] = next_tx_sh[7];
        end
        SFS_LANE_DUAL: begin
          next_oe_n = 4'hC;
          next_io[1:0] = next_tx_sh[7:6];
        end
        default: begin
          next_oe_n = 4'h0;
          next_io = next_tx_sh[7:4];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {io_line_3_o, io_line_2_o, io_line_1_o, io_line_0_o} <= 4'hF;
      {io_line_3_oe_n_o, io_line_2_oe_n_o,
       io_line_1_oe_n_o, io_line_0_oe_n_o}                 <= 4'hF;
    end else begin
      {io_line_3_o, io_line_2_o, io_line_1_o, io_line_0_o} <= next_io;
      {io_line_3_oe_n_o, io_line_2_oe_n_o,
       io_line_1_oe_n_o, io_line_0_oe_n_o}                 <= next_oe_n;
    end
  end

  logic [23:0] addr_lin, next_addr;
  logic [8:0]  next_prog;
  logic        wp_low, next_prot, next_addr_valid;
  logic [6:0]  prot_blocks;

  // Address bytes after the instruction, then the program count
  always_comb begin
    next_addr       = addr_lin;
    next_addr_valid = addr_valid_o;
    next_prog       = prog_count_o;
    if (!active) begin
      next_addr_valid = 1'b0;
      next_prog       = '0;
    end else if (rx_push) begin
      if (byte_cnt >= `SFS_ADDR_FIRST && byte_cnt <= `SFS_ADDR_LAST)
        next_addr = {addr_lin[15:0], rx_byte};
      if (byte_cnt == `SFS_ADDR_LAST) next_addr_valid = 1'b1;
      if (byte_cnt >= `SFS_DATA_FIRST && prog_count_o != `SFS_PAGE_BYTES)
        next_prog = prog_count_o + 9'h001;
    end
  end

  // Write protect pin only counts outside quad mode
  assign wp_low      = !io_s[2] && !quad;
  assign prot_blocks = (protect_range_bits_i >= `SFS_BP_ALL) ? 7'h40 :
                       (protect_range_bits_i == 4'h0) ? 7'h00 :
                       7'(7'h01 << (protect_range_bits_i - 4'h1));
  assign next_prot   = {1'b0, addr_lin[21:16]} >= (7'h40 - prot_blocks);

  // Registered status to the core
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_lin             <= '0;
      addr_valid_o         <= 1'b0;
      prog_count_o         <= '0;
      prog_over_o          <= 1'b0;
      addr_protected_o     <= 1'b0;
      status_write_block_o <= 1'b0;
      selected_o           <= 1'b0;
      cycle_busy_o         <= 1'b0;
      prog_byte_o          <= `SFS_IDLE_BYTE;
      erase_base_o         <= `SFS_CHIP_BASE;
    end else begin
      addr_lin             <= next_addr;
      addr_valid_o         <= next_addr_valid;
      prog_count_o         <= next_prog;
      prog_over_o          <= active && rx_push && byte_cnt >= `SFS_DATA_FIRST
                              && prog_count_o == `SFS_PAGE_BYTES;
      addr_protected_o     <= next_prot && addr_valid_o;
      status_write_block_o <= wp_low && status_lock_bit_i;
      selected_o           <= active;
      cycle_busy_o         <= internal_busy_i;
      prog_byte_o          <= old_byte_i & rx_sh;
      unique case (erase_kind_i)
        SFS_ER_SECTOR: erase_base_o <= addr_lin & `SFS_SECTOR_MASK;
        SFS_ER_BLOCK:  erase_base_o <= addr_lin & `SFS_BLOCK_MASK;
        default:       erase_base_o <= `SFS_CHIP_BASE;
      endcase
    end
  end

  // Upper two address bits lie beyond the array and are dropped on purpose
  assign addr_o = addr_lin[21:0];

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  AST_DESELECT_HIZ: assert property (cs_n_s |=> (next_oe_n == 4'hF) ##0
    {io_line_3_oe_n_o, io_line_2_oe_n_o, io_line_1_oe_n_o, io_line_0_oe_n_o} == 4'hF)
    else $error("Lines driven while deselected");
  AST_POWERUP_ARM: assert property (state == SFS_ST_WAIT_HIGH |-> !rx_push)
    else $error("Byte taken before first select fall");
  AST_RISE_SAMPLE: assert property (rx_push |-> rise && $past(!sclk_s))
    else $error("Byte completed off a rising edge");
  AST_FALL_DRIVE: assert property ($changed(tx_sh) && active |-> $past(fall))
    else $error("Output shifted off a falling edge");
  AST_HOLD_HIZ: assert property (hold_act |=> io_line_1_oe_n_o && io_line_0_oe_n_o)
    else $error("Output driven during pause");
  AST_QUAD_NO_HOLD: assert property (quad |-> !hold_act)
    else $error("Pause active in quad mode");
  AST_WP_QUAD: assert property (status_write_block_o |-> $past(!quad && !io_s[2]))
    else $error("Write protect honoured in quad mode");
  AST_BUSY_HOLDS: assert property (internal_busy_i && cs_n_s |=> cycle_busy_o)
    else $error("Internal cycle dropped on deselect");
  AST_PROG_MAX: assert property (prog_count_o <= `SFS_PAGE_BYTES)
    else $error("Program count past one page");
  AST_PROG_ONES: assert property ((prog_byte_o & ~$past(old_byte_i)) == 8'h00)
    else $error("Program set a bit");
  AST_ERASE_ALIGN: assert property (erase_base_o[11:0] == 12'h000)
    else $error("Erase base not sector aligned");

  COV_QUAD_READ: cover property (active && quad && drive_out_i && fall);
  COV_HOLD: cover property (hold_act ##1 !hold_act && active);
  COV_PAGE_FULL: cover property (prog_count_o == `SFS_PAGE_BYTES);
  COV_OVERRUN: cover property (rx_overrun_o);
endmodule
`default_nettype wire

// ### verif/sfs_host_model.sv
/*
  SPI host model: serial clock, select and I/O lines, bytes MSB first.
  Assumes the bench resolves the shared lines and returns them on io_i.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_host_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Serial pins
  output var  logic       spi_clk_o = 1'b0,
  output var  logic       cs_n_o    = 1'b0,
  output var  logic [3:0] io_o      = 4'hC,
  output var  logic [3:0] io_en_o   = 4'hF,
  input  wire logic [3:0] io_i
);
  localparam int HALF = 8; // Half period in system clocks, well above the minimum
  logic pol    = 1'b0;
  logic wp_n   = 1'b1;
  logic hold_n = 1'b1;

  // Park the pins: write protect and pause levels on lines 2 and 3
  task automatic set_pins(input logic wp, input logic hold);
    wp_n = wp;
    hold_n = hold;
    io_o <= {hold, wp, 2'b00};
    io_en_o <= 4'hF;
    repeat (HALF) @(posedge clk_sys_i);
  endtask

  // Clock parked at its idle level, then a high-to-low select
  task automatic select(input logic cpol);
    pol = cpol;
    spi_clk_o <= cpol;
    cs_n_o <= 1'b1;
    repeat (HALF) @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    repeat (HALF) @(posedge clk_sys_i);
  endtask

  // Clock back to idle, then release select and park the lines
  task automatic deselect();
    repeat (HALF) @(posedge clk_sys_i);
    spi_clk_o <= pol;
    repeat (HALF) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    set_pins(wp_n, hold_n);
  endtask

  // One byte: low phase puts bits out, rising edge samples the device
  task automatic xfer(input logic [7:0] tx, input int lanes, input logic rd,
                      input int pause_at, output logic [7:0] rx);
    logic [3:0] msk;
    logic [3:0] dev;
    logic [3:0] bits;
    msk = 4'((1 << lanes) - 1);
    dev = (lanes == 1) ? 4'h2 : msk;
    rx = 8'h00;
    for (int s = 0; s < 8 / lanes; s++) begin
      if (s == pause_at) begin
        hold_n = 1'b0;
        io_o[3] <= 1'b0;
        repeat (4) begin
          repeat (HALF) @(posedge clk_sys_i);
          spi_clk_o <= ~spi_clk_o;
          io_o[0] <= ~io_o[0];
        end
        repeat (HALF) @(posedge clk_sys_i);
        hold_n = 1'b1;
        io_o[3] <= 1'b1;
        repeat (HALF) @(posedge clk_sys_i);
      end
      bits = 4'(tx >> (8 - lanes * (s + 1))) & msk;
      spi_clk_o <= 1'b0;
      io_o <= (lanes == 4) ? bits : {hold_n, wp_n, bits[1:0]};
      io_en_o <= rd ? ~dev : 4'hF;
      repeat (HALF) @(posedge clk_sys_i);
      spi_clk_o <= 1'b1;
      rx = 8'((rx << lanes) | ((lanes == 1) ? 4'(io_i[1]) : io_i & msk));
      repeat (HALF) @(posedge clk_sys_i);
    end
  endtask
endmodule
`default_nettype wire

// ### verif/sfs_front_end_tb_top.sv
/*
  Bench of the serial flash front end: host model on the pins, queue
  model of received bytes, checks of address, counts and drivers.
  Assumes rtl/ sources and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module sfs_front_end_tb_top;
  import sfs_pkg::*;
  logic        clk_sys_i            = 1'b0;
  logic        reset_n_i            = 1'b0;
  logic        spi_clk, cs_n, tog   = 1'b0;
  logic [3:0]  host_io, host_en, dev_o, oe_n, io_wire;
  sfs_lane_e   lane_mode_i          = SFS_LANE_SINGLE;
  logic        drive_out_i          = 1'b0;
  logic        internal_busy_i      = 1'b0;
  logic        status_lock_bit_i    = 1'b0;
  logic [3:0]  protect_range_bits_i = 4'h0;
  sfs_erase_e  erase_kind_i         = SFS_ER_SECTOR;
  logic [7:0]  old_byte_i           = 8'hFF;
  logic        rx_ready_i           = 1'b0;
  logic        tx_valid_i           = 1'b0;
  logic [7:0]  tx_data_i            = 8'hFF;
  logic        rx_valid_o, rx_overrun_o, tx_ack_o, selected_o, cycle_busy_o;
  logic        addr_valid_o, addr_protected_o, status_write_block_o, prog_over_o;
  sfs_rx_s     rx_o;
  sfs_addr_s   addr_o;
  logic [8:0]  prog_count_o;
  logic [7:0]  prog_byte_o, junk;
  logic [23:0] erase_base_o;
  logic        stall                = 1'b0;
  logic [31:0] seed                 = 32'h00003A09;
  int          bad_count            = 0;
  int          cmp_count            = 0;
  int          over_cnt             = 0;
  logic [8:0]  exp_q[$];
  logic [7:0]  tx_q[$];

  // Clock and a toggling level for lines that nobody drives
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) tog <= ~tog;
  assign io_wire = (~oe_n & dev_o) | (oe_n & host_en & host_io) | (oe_n & ~host_en & {4{tog}});

  sfs_host_model host (.clk_sys_i, .spi_clk_o(spi_clk), .cs_n_o(cs_n), .io_o(host_io),
                       .io_en_o(host_en), .io_i(io_wire));

  sfs_front_end dut (.clk_sys_i, .reset_n_i, .spi_clk_i(spi_clk), .chip_sel_n_i(cs_n),
    .io_line_0_i(io_wire[0]), .io_line_1_i(io_wire[1]), .io_line_2_i(io_wire[2]),
    .io_line_3_i(io_wire[3]), .io_line_0_o(dev_o[0]), .io_line_1_o(dev_o[1]),
    .io_line_2_o(dev_o[2]), .io_line_3_o(dev_o[3]), .io_line_0_oe_n_o(oe_n[0]),
    .io_line_1_oe_n_o(oe_n[1]), .io_line_2_oe_n_o(oe_n[2]), .io_line_3_oe_n_o(oe_n[3]),
    .lane_mode_i, .drive_out_i, .internal_busy_i, .status_lock_bit_i,
    .protect_range_bits_i, .erase_kind_i, .old_byte_i, .rx_valid_o, .rx_o, .rx_ready_i,
    .rx_overrun_o, .tx_valid_i, .tx_data_i, .tx_ack_o, .selected_o, .cycle_busy_o,
    .addr_o, .addr_valid_o, .addr_protected_o, .status_write_block_o, .prog_count_o,
    .prog_over_o, .prog_byte_o, .erase_base_o);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic sfs_lane_e lane_of(input int lanes);
    return (lanes == 4) ? SFS_LANE_QUAD : (lanes == 2) ? SFS_LANE_DUAL : SFS_LANE_SINGLE;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Core side: random pops compared with the queue, next byte on ack
  always @(posedge clk_sys_i) begin
    rx_ready_i <= !stall && rnd() > 32'h7FFFFFFF;
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
      if (exp_q.size() == 0) check("rx_extra", 1, 0);
      else check("rx_byte", rx_o, exp_q.pop_front());
    end
    if (prog_over_o === 1'b1) over_cnt++;
    if (tx_ack_o === 1'b1) begin
      if (tx_q.size() > 0) void'(tx_q.pop_front());
      tx_data_i <= (tx_q.size() > 0) ? tx_q[0] : 8'hFF;
      tx_valid_i <= tx_q.size() > 0;
    end
  end

  // Receive frame: instruction, address MSB first, then n data bytes
  task automatic rx_frame(input int lanes, input int n, input int pause_at, input int keep);
    logic [23:0] addr;
    logic [23:0] msk;
    logic [7:0]  d;
    logic        hit;
    addr = {2'b00, 22'(rnd())};
    old_byte_i <= 8'(rnd());
    over_cnt = 0;
    lane_mode_i <= lane_of(lanes);
    host.select(1'b0);
    for (int i = 0; i < n + 4; i++) begin
      d = (i == 0) ? 8'h02 : (i < 4) ? addr[8 * (3 - i) +: 8] : 8'(rnd());
      if (i < keep) exp_q.push_back({i == 0, d});
      host.xfer(d, lanes, 1'b0, (i == 1) ? pause_at : -1, junk);
    end
    repeat (6) @(posedge clk_sys_i);
    check("selected_on", selected_o, 1);
    check("addr_valid", addr_valid_o, 1);
    check("addr", addr_o, addr);
    check("prog_count", prog_count_o, (n > 256) ? 256 : n);
    check("prog_over", over_cnt, (n > 256) ? n - 256 : 0);
    check("prog_byte", prog_byte_o, old_byte_i & d);
    check("overrun", rx_overrun_o, n + 4 > keep);
    for (int k = 0; k < 3; k++) begin
      erase_kind_i <= sfs_erase_e'(k);
      msk = (k == 0) ? 24'hFFF000 : (k == 1) ? 24'hFF0000 : 24'h000000;
      repeat (3) @(posedge clk_sys_i);
      check("erase_base", erase_base_o, addr & msk);
    end
    for (int p = 0; p < 16; p++) begin
      protect_range_bits_i <= 4'(p);
      repeat (3) @(posedge clk_sys_i);
      hit = (p >= 7) || (p > 0 && addr[21:16] >= 64 - (1 << (p - 1)));
      check("protected", addr_protected_o, hit);
    end
    host.deselect();
    check("float", oe_n, 4'hF);
    check("overrun_clr", rx_overrun_o, 0);
  endtask

  // Send frame: instruction in, then two bytes out on the mode's lanes
  task automatic send_test(input int lanes, input logic cpol);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] got;
    a = 8'(rnd());
    b = 8'(rnd());
    lane_mode_i <= lane_of(lanes);
    host.select(cpol);
    exp_q.push_back({1'b1, 8'h0B});
    host.xfer(8'h0B, lanes, 1'b0, -1, got);
    tx_q = '{a, b};
    tx_data_i <= a;
    tx_valid_i <= 1'b1;
    drive_out_i <= 1'b1;
    host.xfer(8'hFF, lanes, 1'b1, -1, got);
    check("tx_first", got, a);
    check("oe_n", oe_n, (lanes == 4) ? 4'h0 : (lanes == 2) ? 4'hC : 4'hD);
    host.xfer(8'hFF, lanes, 1'b1, -1, got);
    check("tx_second", got, b);
    host.deselect();
    check("float", oe_n, 4'hF);
    drive_out_i <= 1'b0;
  endtask

  // Watchdog: the whole run needs about 12k cycles
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    bad_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    host.xfer(8'hA5, 1, 1'b0, -1, junk);
    repeat (6) @(posedge clk_sys_i);
    check("selected", selected_o, 0);
    rx_frame(1, 3, -1, 999);
    rx_frame(2, 2, 3, 999); // pause in mid-byte
    rx_frame(4, 257, -1, 999);
    stall = 1'b1;
    rx_frame(1, 0, -1, 2);
    stall = 1'b0;
    send_test(1, 1'b0);
    send_test(2, 1'b1);
    send_test(4, 1'b0);
    host.select(1'b0);
    internal_busy_i <= 1'b1;
    host.deselect();
    check("busy_held", cycle_busy_o, 1);
    internal_busy_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    check("busy_done", cycle_busy_o, 0);
    for (int q = 0; q < 8; q++) begin
      lane_mode_i <= q[2] ? SFS_LANE_QUAD : SFS_LANE_SINGLE;
      status_lock_bit_i <= q[0];
      host.set_pins(q[1], 1'b1);
      check("wr_block", status_write_block_o, !q[2] & !q[1] & q[0]);
    end
    repeat (400) if (exp_q.size() != 0) @(posedge clk_sys_i);
    check("rx_left", exp_q.size(), 0);
    finish_test();
  end
endmodule
`default_nettype wire
